//--- bsq_sequencer.sv
module bsq_sequencer (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic start, // Host controller start pulse
	input wire logic [bsq_pkg::ADDR_W-1:0] start_ptr, // Initial list pointer
	output bsq_pkg::bsq_mem_req_s mem_req, // RAM read request
	input wire bsq_pkg::bsq_mem_rsp_s mem_rsp, // RAM read answer
	input wire logic [7:0] msg_flags, // Message result codes 8..F
	input wire logic [7:0] host_flag_set, // Host sets flags
	input wire logic [7:0] host_flag_clr, // Host clears flags
	output logic [7:0] general_purpose_flag, // Flags 0..7
	output logic msg_start, // Start message pulse
	output logic [bsq_pkg::ADDR_W-1:0] msg_block, // Message block address
	input wire logic msg_done, // Message finished pulse
	output logic [bsq_pkg::ADDR_W-1:0] list_ptr, // Current list pointer
	output logic running, // Engine active
	output bsq_pkg::bsq_irq_s irq // Interrupt event pulses
);
	import bsq_pkg::*;

	typedef struct packed {
		bsq_state_e st;
		logic [ADDR_W-1:0] ptr;
		logic [WORD_W-1:0] opw;
		logic [WORD_W-1:0] prm;
		logic [7:0] gp;
		logic [STACK_PTR_W-1:0] sp;
		logic [STACK_DEPTH-1:0][ADDR_W-1:0] stk;
		logic msg_start;
		logic [ADDR_W-1:0] msg_block;
		logic tmr_load;
		bsq_irq_s irq;
	} bsq_seq_s;

	bsq_seq_s r, next_r;
	bsq_check_s chk;
	logic tmr_busy;
	logic [15:0] codes;
	logic cond_true;
	logic [4:0] op;
	logic [7:0] gp_host;
	logic [7:0] gp_flag_op;

	bsq_op_check u_check (
		.word(r.opw),
		.chk(chk)
	);

	// Delay shares the message gap timer instead of its own counter
	bsq_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.load(r.tmr_load),
		.us_value(r.prm),
		.busy(tmr_busy)
	);

	// Condition test: low nibble picks the code, bit four is the wanted level
	always_comb begin
		codes = {msg_flags, r.gp};
		cond_true = (codes[r.opw[3:0]] == r.opw[SENSE_BIT]);
		op = r.opw[OP_HI:OP_LO];
	end

	// Host flag writes; set wins so a same-cycle clear cannot hide a set
	always_comb begin
		gp_host = (r.gp & ~host_flag_clr) | host_flag_set;
	end

	// Flag op per bit: low byte sets, high byte clears, both toggles
	for (genvar i = 0; i < 8; i++) begin : g_flag_op
		assign gp_flag_op[i] = r.prm[i + 8] ? (r.prm[i] & ~gp_host[i]) : (r.prm[i] | gp_host[i]);
	end

	// Main sequence machine
	always_comb begin
		next_r = r;
		next_r.msg_start = 1'b0;
		next_r.tmr_load = 1'b0;
		next_r.irq = '0;
		next_r.gp = gp_host;
		unique case (r.st)
			ST_IDLE, ST_HALTED: begin
				if (start) begin
					next_r.ptr = start_ptr;
					next_r.st = ST_FETCH_OP;
				end
			end
			ST_FETCH_OP: begin
				next_r.st = ST_WAIT_OP;
			end
			ST_WAIT_OP: begin
				if (mem_rsp.valid) begin
					next_r.opw = mem_rsp.data;
					next_r.st = ST_FETCH_PRM;
				end
			end
			ST_FETCH_PRM: begin
				// Check the op word before spending a fetch on its parameter
				if (chk.bad) begin
					next_r.st = ST_HALTED;
					next_r.irq.trap = 1'b1;
					next_r.irq.parity = chk.parity_err;
				end else begin
					next_r.st = ST_WAIT_PRM;
				end
			end
			ST_WAIT_PRM: begin
				if (mem_rsp.valid) begin
					next_r.prm = mem_rsp.data;
					next_r.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_r.ptr = r.ptr + PAIR_STEP;
				next_r.st = ST_FETCH_OP;
				if (op == OP_FLAG) begin
					// Unconditional; untouched bits keep the host's update
					next_r.gp = gp_flag_op;
				end else if (cond_true) begin
					unique case (op)
						OP_EXEC: begin
							next_r.msg_start = 1'b1;
							next_r.msg_block = r.prm;
							next_r.st = ST_MSG;
						end
						OP_JUMP: begin
							next_r.ptr = r.prm;
						end
						OP_CALL: begin
							if (r.sp == STACK_PTR_W'(STACK_DEPTH)) begin
								next_r.irq.stack_err = 1'b1;
								next_r.st = ST_HALTED;
							end else begin
								next_r.stk[r.sp[1:0]] = r.ptr + PAIR_STEP;
								next_r.sp = r.sp + STACK_PTR_W'(1);
								next_r.ptr = r.prm;
							end
						end
						OP_RETURN: begin
							if (r.sp == '0) begin
								next_r.irq.stack_err = 1'b1;
								next_r.st = ST_HALTED;
							end else begin
								next_r.ptr = r.stk[2'(r.sp - STACK_PTR_W'(1))];
								next_r.sp = r.sp - STACK_PTR_W'(1);
							end
						end
						OP_IRQ: begin
							next_r.irq.user_irq = r.prm[3:0];
						end
						OP_HALT: begin
							next_r.st = ST_HALTED;
						end
						OP_DELAY: begin
							next_r.tmr_load = 1'b1;
							next_r.st = ST_DELAY;
						end
						default: begin
							next_r.st = ST_HALTED;
						end
					endcase
				end
				// False condition only advances the pointer
			end
			ST_MSG: begin
				if (msg_done) begin
					next_r.st = ST_FETCH_OP;
				end
			end
			ST_DELAY: begin
				// Timer loads one cycle after entry, so skip the first look
				if (!r.tmr_load && !tmr_busy) begin
					next_r.st = ST_FETCH_OP;
				end
			end
			default: begin
				next_r.st = ST_HALTED;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Read requests: op word at pointer, parameter at pointer plus one
	always_comb begin
		mem_req.req = (r.st == ST_FETCH_OP) || ((r.st == ST_FETCH_PRM) && !chk.bad);
		mem_req.addr = (r.st == ST_FETCH_PRM) ? r.ptr + ADDR_STEP : r.ptr;
	end

	assign general_purpose_flag = r.gp;
	assign msg_start = r.msg_start;
	assign msg_block = r.msg_block;
	assign list_ptr = r.ptr;
	assign running = (r.st != ST_IDLE) && (r.st != ST_HALTED);
	assign irq = r.irq;
endmodule

//--- bsq_pkg.sv
// Contract
// - Fetch op code word, then parameter word
// - Low four condition bits select, bit four sense
// - Halt on bad op code, parity, pattern
// - Trap interrupt on invalid op code halt
// - Parity interrupt when halt from even parity
// - Flag update sets, clears, toggles eight flags
// - False condition: no action, next pair (a flag update still applies its parameter)
// - Execute message starts block at parameter
// - Jump loads pointer from parameter
// - Four-entry stack; overrun/underrun raises error
// - Return pops address; parameter ignored
// - Interrupt request copies four parameter bits
// - Zero pattern produces no interrupt
// - Halt stops until new host start
// - Delay waits parameter microseconds when true
// - Delay uses time-to-next-message timer
package bsq_pkg;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam logic [4:0] OP_EXEC = 5'h01;
	localparam logic [4:0] OP_JUMP = 5'h02;
	localparam logic [4:0] OP_CALL = 5'h03;
	localparam logic [4:0] OP_RETURN = 5'h04;
	localparam logic [4:0] OP_FLAG = 5'h05;
	localparam logic [4:0] OP_IRQ = 5'h06;
	localparam logic [4:0] OP_HALT = 5'h07;
	localparam logic [4:0] OP_DELAY = 5'h08;
	localparam logic [4:0] FIXED_PATTERN = 5'h0A;
	localparam int PAR_BIT = 15;
	localparam int OP_HI = 14;
	localparam int OP_LO = 10;
	localparam int PAT_HI = 9;
	localparam int PAT_LO = 5;
	localparam int SENSE_BIT = 4;
	localparam int STACK_DEPTH = 4;
	localparam int STACK_PTR_W = 3;
	localparam int CLK_MHZ = 200;
	localparam int US_NS = 1000;
	localparam int CLK_NS = 5;
	localparam logic [7:0] US_CYCLES = 8'(US_NS / CLK_NS);
	localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
	localparam logic [ADDR_W-1:0] PAIR_STEP = 16'h0002;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_FETCH_OP = 4'b0001,
		ST_WAIT_OP = 4'b0010,
		ST_FETCH_PRM = 4'b0011,
		ST_WAIT_PRM = 4'b0100,
		ST_EXEC = 4'b0101,
		ST_MSG = 4'b0110,
		ST_DELAY = 4'b0111,
		ST_HALTED = 4'b1000
	} bsq_state_e;

	// Memory read request/answer toward shared RAM
	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} bsq_mem_req_s;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
	} bsq_mem_rsp_s;

	// Decoded fault report of one op code word
	typedef struct packed {
		logic bad;
		logic parity_err;
	} bsq_check_s;

	// Event pulses toward the interrupt status logic
	typedef struct packed {
		logic trap;
		logic parity;
		logic stack_err;
		logic [3:0] user_irq;
	} bsq_irq_s;
endpackage

//--- bsq_op_check.sv
module bsq_op_check (
	input wire logic [bsq_pkg::WORD_W-1:0] word, // Fetched op code word
	output bsq_pkg::bsq_check_s chk // Fault report
);
	import bsq_pkg::*;
	logic [4:0] op;
	logic defined;
	// Pure decode; the caller samples it only while the op word is held
	always_comb begin
		op = word[OP_HI:OP_LO];
		defined = (op >= OP_EXEC) && (op <= OP_DELAY);
		chk.parity_err = ~(^word);
		chk.bad = ~defined | chk.parity_err | (word[PAT_HI:PAT_LO] != FIXED_PATTERN);
	end
endmodule

//--- bsq_timer.sv
module bsq_timer (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic load, // Load pulse
	input wire logic [bsq_pkg::WORD_W-1:0] us_value, // Time in microseconds
	output logic busy // Counting
);
	import bsq_pkg::*;
	typedef struct packed {
		logic [WORD_W-1:0] us_left;
		logic [7:0] div;
	} bsq_tmr_s;
	bsq_tmr_s r, next_r;
	// Shared time-to-next-message timer; busy while microseconds remain
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.us_left = us_value;
			next_r.div = US_CYCLES - 8'h01;
		end else if (r.us_left != '0) begin
			if (r.div == 8'h00) begin
				next_r.div = US_CYCLES - 8'h01;
				next_r.us_left = r.us_left - WORD_W'(1);
			end else begin
				next_r.div = r.div - 8'h01;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign busy = (r.us_left != '0);
endmodule

//--- bsq_ram_model.sv
module bsq_ram_model
	import bsq_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic slow, // Answer late
	input wire bsq_pkg::bsq_mem_req_s mem_req, // Read
	output bsq_pkg::bsq_mem_rsp_s mem_rsp // Word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] mem [0:63];
	logic [5:0] a;
	int w = -1;
	initial mem_rsp = '0;
	// Idle data toggles so a late sample cannot pass by luck
	always @(posedge mclk) begin
		mem_rsp <= {1'b0, ~mem_rsp.data};
		if (mem_req.req) begin
			a <= mem_req.addr[5:0];
			w <= slow ? 3 : 0;
		end else if (w > 0) w <= w - 1;
		else if (w == 0) begin
			mem_rsp <= {1'b1, mem[a]};
			w <= -1;
		end
	end
endmodule

//--- bsq_sequencer_assertions.sv
module bsq_sequencer_assertions
	import bsq_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset
	input wire logic start, // Start
	input wire bsq_pkg::bsq_mem_req_s mem_req, // Read
	input wire bsq_pkg::bsq_mem_rsp_s mem_rsp, // Word
	input wire logic msg_start, // Message
	input wire logic [bsq_pkg::ADDR_W-1:0] msg_block, // Block
	input wire logic running, // Active
	input wire bsq_pkg::bsq_irq_s irq // Events
);
	logic ph;
	logic [ADDR_W-1:0] la, lp;
	wire logic [WORD_W-1:0] d = mem_rsp.data;
	wire logic op = mem_rsp.valid && !ph;
	wire logic bad = op && (!(^d) || d[9:5] != FIXED_PATTERN || d[14:10] == 5'h00 || d[14:10] > OP_DELAY);
	// Answers alternate op word and parameter; a new start realigns
	always_ff @(posedge mclk) begin
		if (!rst_n || start || !running) ph <= 1'b0;
		else if (mem_rsp.valid) ph <= !ph;
		if (mem_req.req) la <= mem_req.addr;
		if (mem_rsp.valid && ph) lp <= d;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_fault_trap: assert property (bad |-> ##[1:2] irq.trap) else $error("no trap");
	a_fault_stop: assert property (bad |-> ##1 (!mem_req.req) [*3]) else $error("fetch after fault");
	a_parity_irq: assert property (op && !(^d) |-> ##[1:2] irq.parity) else $error("no parity event");
	a_parity_cause: assert property (irq.parity |-> irq.trap) else $error("parity alone");
	a_param_addr: assert property (mem_req.req && ph |-> mem_req.addr == la + ADDR_STEP) else $error("param addr");
	a_msg_block: assert property (msg_start |-> msg_block == lp) else $error("block addr");
	a_halt_hold: assert property (!running && !start |=> !running) else $error("ran unstarted");
	a_stack_halt: assert property (irq.stack_err |-> ##[0:2] !running) else $error("stack ran on");
	c_msg: cover property (msg_start);
	c_parity: cover property (irq.parity);
	c_stack: cover property (irq.stack_err);
endmodule

bind bsq_sequencer bsq_sequencer_assertions chk_u (.mclk, .rst_n, .start, .mem_req, .mem_rsp, .msg_start,
	.msg_block, .running, .irq);

//--- bsq_sequencer_tb.sv
module bsq_sequencer_tb;
	import bsq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_n = 1'b0, start = 1'b0, slow = 1'b0, msg_done = 1'b0;
	logic [7:0] fset = 8'h00, fclr = 8'h00, gpf, mflags = 8'h00;
	logic [15:0] sp = 16'h0000, msg_block, lptr;
	logic [3:0] md = 4'h0, uirq;
	logic msg_start, running;
	bsq_mem_req_s mem_req;
	bsq_mem_rsp_s mem_rsp;
	bsq_irq_s irq;
	int mismatches = 0, checked = 0, cyc = 0, trap_n, par_n, stk_n, msg_n, uirq_n;
	logic [15:0] reqs[$];
	int tms[$];
	always #2.5 mclk = ~mclk;
	bsq_sequencer dut_u (.mclk, .rst_n, .start, .start_ptr(sp), .mem_req, .mem_rsp, .msg_flags(mflags),
		.host_flag_set(fset), .host_flag_clr(fclr), .general_purpose_flag(gpf), .msg_start, .msg_block,
		.msg_done, .list_ptr(lptr), .running, .irq);
	bsq_ram_model ram_u (.mclk, .slow, .mem_req, .mem_rsp);
	// Message side answers a few cycles after each start; events are tallied
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		md <= {md[2:0], msg_start};
		msg_done <= md[3];
		if (mem_req.req) begin
			reqs.push_back(mem_req.addr);
			tms.push_back(cyc);
		end
		trap_n += irq.trap;
		par_n += irq.parity;
		stk_n += irq.stack_err;
		msg_n += msg_start;
		if (irq.user_irq != 4'h0) begin
			uirq |= irq.user_irq;
			uirq_n++;
		end
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	function automatic logic [15:0] mk(logic [4:0] op, logic [4:0] pat, logic [4:0] c);
		return {~^{op, pat, c}, op, pat, c};
	endfunction
	task automatic put(logic [15:0] a, logic [4:0] op, logic [4:0] c, logic [15:0] p);
		ram_u.mem[a] = mk(op, FIXED_PATTERN, c);
		ram_u.mem[a + 1] = p;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Start at p and wait for the engine to stop by itself
	task automatic run(logic [15:0] p);
		{trap_n, par_n, stk_n, msg_n, uirq_n} = '0;
		uirq = 4'h0;
		reqs = {};
		tms = {};
		start <= 1'b1;
		sp <= p;
		@(posedge mclk);
		start <= 1'b0;
		#1;
		while (running !== 1'b0) begin
			@(posedge mclk);
			#1;
		end
		repeat (3) @(posedge mclk);
	endtask
	// Skips, jump, flags, message, call, delay, return and halt in one walk
	task automatic t_flow(logic s);
		logic [15:0] ex[$];
		ex = {16'h00, 16'h02, 16'h04, 16'h06, 16'h0C, 16'h0E, 16'h10, 16'h18, 16'h1A, 16'h12};
		slow <= s;
		fclr <= 8'hFF;
		@(posedge mclk);
		fclr <= 8'h00;
		run(16'h0000);
		chk(reqs.size(), 2 * ex.size());
		foreach (ex[i]) chk(reqs[2 * i], ex[i]);
		chk(uirq, 4'h5);
		chk(uirq_n, 1);
		chk(gpf, 8'h06);
		chk(msg_n, 1);
		chk(msg_block, 16'h0020);
		chk(tms[16] - tms[15] inside {[400:415]}, 1);
		chk(lptr, 16'h0014);
	endtask
	// Each malformed op word stops the engine before its parameter is read
	task automatic t_fault();
		logic [15:0] w[4];
		w = '{mk(OP_JUMP, 5'h0B, 5'h00), mk(5'h00, FIXED_PATTERN, 5'h00), mk(5'h09, FIXED_PATTERN, 5'h00),
			mk(OP_JUMP, FIXED_PATTERN, 5'h00) ^ 16'h8000};
		foreach (w[i]) begin
			ram_u.mem[40] = w[i];
			run(16'h0028);
			chk(reqs.size(), 1);
			chk(trap_n, 1);
			chk(par_n, i == 3);
			chk(lptr, 16'h0028);
		end
	endtask
	// Sense bit one tests the flag as set; then underrun and overrun
	task automatic t_stack();
		fset <= 8'h01;
		@(posedge mclk);
		fset <= 8'h00;
		run(16'h0030);
		chk(stk_n, 1);
		run(16'h0032);
		chk(stk_n, 1);
		chk(reqs.size(), 10);
	endtask
	// Message result codes as conditions in both senses; a false delay costs no time
	task automatic t_cond();
		mflags <= 8'h08;
		run(16'h0038);
		chk(reqs.size(), 8);
		chk(uirq, 4'h2);
		chk(uirq_n, 1);
		chk(tms[6] - tms[5] < 16, 1);
		chk(lptr, 16'h0040);
	endtask
	initial begin
		put(16'h00, OP_IRQ, 5'h00, 16'hFFF5);
		put(16'h02, OP_IRQ, 5'h10, 16'h0003);
		put(16'h04, OP_IRQ, 5'h00, 16'h0010);
		put(16'h06, OP_JUMP, 5'h00, 16'h000C);
		put(16'h08, OP_HALT, 5'h00, 16'h0000);
		put(16'h0C, OP_FLAG, 5'h00, 16'h0306);
		put(16'h0E, OP_EXEC, 5'h00, 16'h0020);
		put(16'h10, OP_CALL, 5'h00, 16'h0018);
		put(16'h12, OP_HALT, 5'h00, 16'h0000);
		put(16'h18, OP_DELAY, 5'h00, 16'h0002);
		put(16'h1A, OP_RETURN, 5'h00, 16'hBEEF);
		put(16'h30, OP_RETURN, 5'h10, 16'h0000);
		put(16'h32, OP_CALL, 5'h10, 16'h0032);
		put(16'h38, OP_IRQ, 5'h0B, 16'h0001);
		put(16'h3A, OP_IRQ, 5'h1B, 16'h0002);
		put(16'h3C, OP_DELAY, 5'h0B, 16'hFFFF);
		put(16'h3E, OP_HALT, 5'h1B, 16'h0000);
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_flow(1'b0);
		t_flow(1'b1);
		t_fault();
		t_stack();
		t_cond();
		complete_run();
	end
endmodule
